/* addr_map_pkg.sv */
// How it works
// - program counter drives a 16-bit program memory address every fetch
// - register file has its own 8-bit address and data bus
// - program memory size follows variant: 64, 32 or 16 kilobytes
// - lowest 256 program addresses are the vector area, still fetchable
// - reset loads the program counter with 0100h
// - 256 physical bytes appear as 320 through addressing mode
// - separate 38-byte display data area
// - top 64 bytes decode into set 1 and set 2
// - set 1 upper 32 bytes banked, lower 32 common
// - set 1 reachable whatever page is selected
// - only register modes reach set 1; others go elsewhere
// - bank follows last bank-select; page follows page selector
// - largest variant: ten 256-byte pages plus system, display areas
// - reset selects bank 0
// - reset clears both page selector nibbles
// - set 2 reached only by indirect or indexed modes
package addr_map_pkg;
    // ------------------------------------------------------------------
    // program memory
    // ------------------------------------------------------------------
    localparam int PM_AW = 16;
    localparam logic [15:0] RESET_PC = 16'h0100;
    localparam logic [15:0] VECTOR_END = 16'h0100;
    localparam int ROM_KB_LARGE = 64;
    localparam int ROM_KB_MIDDLE = 32;
    localparam int ROM_KB_SMALL = 16;
    localparam int PAGES_LARGE = 10;
    localparam int PAGES_MIDDLE = 4;
    localparam int PAGES_SMALL = 2;
    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    localparam int RB_W = 8;
    localparam int STORE_AW = 12;
    localparam int STORE_DEPTH = 4096;
    localparam logic [7:0] SET1_LO = 8'hc0;
    localparam logic [7:0] BANK_LO = 8'he0;
    localparam logic [7:0] PAGE_SEL_ADDR = 8'hdf;
    localparam logic [7:0] LCD_BYTES = 8'h26;
    localparam logic [3:0] LCD_PAGE = 4'hf;
    localparam logic [11:0] SET1_COMMON_BASE = 12'ha00;
    localparam logic [11:0] BANK0_BASE = 12'ha20;
    localparam logic [11:0] BANK1_BASE = 12'ha40;
    localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
    typedef enum logic [1:0] {
        MODE_REGISTER,
        MODE_WORKING,
        MODE_INDIRECT,
        MODE_INDEXED
    } addr_mode_type;
endpackage : addr_map_pkg

/* reg_store.sv */
`timescale 1ns/1ns
module reg_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4096,
    parameter int AW = 12
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic wr_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    input wire logic rd_in,
    input wire logic [AW-1:0] raddr_in,
    output logic [WIDTH-1:0] rdata_out
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys_in) begin
        if (wr_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            rdata_out <= mem[raddr_in];
        end
    end
endmodule : reg_store

/* register_file_address_map.sv */
`timescale 1ns/1ns
module register_file_address_map #(
    parameter int ROM_KB = addr_map_pkg::ROM_KB_LARGE,
    parameter int PAGES = addr_map_pkg::PAGES_LARGE
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic pc_step_in,
    input wire logic pc_load_in,
    input wire logic [15:0] pc_target_in,
    output logic [15:0] pm_addr_out,
    output logic pm_vector_out,
    output logic pm_range_err_out,
    input wire logic [7:0] rb_addr_in,
    input wire logic [7:0] rb_wdata_in,
    input wire logic [1:0] rb_mode_in,
    input wire logic rb_wr_in,
    input wire logic rb_rd_in,
    output logic [7:0] rb_rdata_out,
    output logic rb_rvalid_out,
    output logic rb_err_out,
    input wire logic select_bank_zero_instr_in,
    input wire logic select_bank_one_instr_in,
    output logic bank_sel_out,
    output logic [7:0] register_page_selector_out
);
    localparam logic [16:0] ROM_BYTES = 17'(ROM_KB * 1024);

    // ------------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------------
    logic [15:0] pc_next;
    wire [15:0] pc_inc = pm_addr_out + 16'h0001;

    assign pc_next = pc_load_in ? pc_target_in :
                     pc_step_in ? pc_inc : pm_addr_out;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pm_addr_out <= addr_map_pkg::RESET_PC;
            pm_vector_out <= 1'b0;
            pm_range_err_out <= 1'b0;
        end else begin
            pm_addr_out <= pc_next;
            // vector area stays fetchable; flag only marks it
            pm_vector_out <= pc_next < addr_map_pkg::VECTOR_END;
            pm_range_err_out <= {1'b0, pc_next} >= ROM_BYTES;
        end
    end

    // ------------------------------------------------------------------
    // bank and page selection
    // ------------------------------------------------------------------
    wire reg_mode = rb_mode_in == addr_map_pkg::MODE_REGISTER ||
                    rb_mode_in == addr_map_pkg::MODE_WORKING;
    wire in_top = rb_addr_in >= addr_map_pkg::SET1_LO;
    wire set1_hit = in_top && reg_mode;
    wire set2_hit = in_top && !reg_mode;
    wire page_sel_hit = set1_hit && rb_addr_in == addr_map_pkg::PAGE_SEL_ADDR;
    logic bank_next;

    // bank-select one wins if both arrive together
    assign bank_next = select_bank_one_instr_in ? 1'b1 :
                       select_bank_zero_instr_in ? 1'b0 :
                       bank_sel_out;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            bank_sel_out <= 1'b0;
            register_page_selector_out <=
                addr_map_pkg::PAGE_SEL_RESET;
        end else begin
            bank_sel_out <= bank_next;
            if (rb_wr_in && page_sel_hit) begin
                register_page_selector_out <= rb_wdata_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // address decode: source page for reads, destination page for writes
    // ------------------------------------------------------------------
    wire [3:0] src_page = register_page_selector_out[3:0];
    wire [3:0] dst_page = register_page_selector_out[7:4];
    wire [3:0] page = rb_wr_in ? dst_page : src_page;
    wire lcd_page = page == addr_map_pkg::LCD_PAGE;
    wire page_ok = {28'h0, page} < 32'(PAGES);
    wire [11:0] set1_index = {7'h0, rb_addr_in[4:0]} + (
        rb_addr_in < addr_map_pkg::BANK_LO ? addr_map_pkg::SET1_COMMON_BASE :
        bank_sel_out ? addr_map_pkg::BANK1_BASE :
        addr_map_pkg::BANK0_BASE);
    // page selection never applies to set 1
    wire [11:0] phys_index = set1_hit ? set1_index :
                             {page, rb_addr_in};
    wire lcd_ok = lcd_page && !in_top &&
                  rb_addr_in < addr_map_pkg::LCD_BYTES;
    wire mapped = set1_hit || (page_ok && !lcd_page) || lcd_ok;
    wire store_wr = rb_wr_in && mapped && !page_sel_hit;
    wire store_rd = rb_rd_in && !rb_wr_in && mapped && !page_sel_hit;

    logic [7:0] store_q;

    reg_store #(
        .WIDTH(addr_map_pkg::RB_W),
        .DEPTH(addr_map_pkg::STORE_DEPTH),
        .AW(addr_map_pkg::STORE_AW)
    ) u_store (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .wr_in(store_wr),
        .waddr_in(phys_index),
        .wdata_in(rb_wdata_in),
        .rd_in(store_rd),
        .raddr_in(phys_index),
        .rdata_out(store_q)
    );

    // ------------------------------------------------------------------
    // read return: two cycles after the request
    // ------------------------------------------------------------------
    logic rd_pend_reg;
    logic sel_rd_reg;
    logic err_reg;

    wire rd_take = rb_rd_in && !rb_wr_in;
    wire [7:0] rdata_next = sel_rd_reg ? register_page_selector_out :
                            err_reg ? 8'h00 : store_q;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rd_pend_reg <= 1'b0;
            sel_rd_reg <= 1'b0;
            err_reg <= 1'b0;
            rb_rdata_out <= 8'h00;
            rb_rvalid_out <= 1'b0;
            rb_err_out <= 1'b0;
        end else begin
            rd_pend_reg <= rd_take;
            sel_rd_reg <= rd_take && page_sel_hit;
            err_reg <= (rd_take || rb_wr_in) && !mapped;
            rb_rvalid_out <= rd_pend_reg;
            rb_rdata_out <= rd_pend_reg ? rdata_next : rb_rdata_out;
            rb_err_out <= err_reg;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence s_read_req;
        rb_rd_in && !rb_wr_in;
    endsequence

    // back-to-back reads are legal, so no idle cycle is demanded first
    sequence s_read_ret;
        ##1 rb_rvalid_out;
    endsequence

    sequence s_err_ret;
        ##1 rb_err_out;
    endsequence

    a_reset_start_pc: assert property (
        @(posedge clk_sys_in) disable iff (1'b0)
        rst_in ##1 !rst_in && !pc_load_in && !pc_step_in
        |-> pm_addr_out == addr_map_pkg::RESET_PC)
        else $error("program counter not at reset start");
    a_bank_reset: assert property (
        @(posedge clk_sys_in) disable iff (1'b0)
        rst_in |=> !bank_sel_out)
        else $error("bank 0 not selected after reset");
    a_page_reset: assert property (
        @(posedge clk_sys_in) disable iff (1'b0)
        rst_in |=> register_page_selector_out == addr_map_pkg::PAGE_SEL_RESET)
        else $error("page selector not cleared by reset");
    a_bank_select: assert property (
        select_bank_one_instr_in |=> bank_sel_out)
        else $error("bank one select ignored");
    a_bank_zero: assert property (
        select_bank_zero_instr_in && !select_bank_one_instr_in
        |=> !bank_sel_out)
        else $error("bank zero select ignored");
    a_page_write: assert property (
        rb_wr_in && rb_mode_in == addr_map_pkg::MODE_REGISTER &&
        rb_addr_in == addr_map_pkg::PAGE_SEL_ADDR
        |=> register_page_selector_out == $past(rb_wdata_in))
        else $error("page selector write lost");
    a_set2_apart: assert property (
        rb_wr_in && rb_mode_in[1] &&
        rb_addr_in == addr_map_pkg::PAGE_SEL_ADDR
        |=> $stable(register_page_selector_out))
        else $error("indirect access reached set 1");
    a_vector_flag: assert property (
        ##1 pm_vector_out == (pm_addr_out < addr_map_pkg::VECTOR_END))
        else $error("vector area flag wrong");
    a_pc_step: assert property (
        pc_step_in && !pc_load_in
        |=> pm_addr_out == $past(pm_addr_out) + 16'h0001)
        else $error("program counter did not step");
    a_pc_load: assert property (
        pc_load_in |=> pm_addr_out == $past(pc_target_in))
        else $error("program counter did not load");
    // page 15 holds only the display bytes below the set 1 range
    a_lcd_limit: assert property (
        s_read_req ##0
        (register_page_selector_out[3:0] == addr_map_pkg::LCD_PAGE &&
         rb_addr_in >= addr_map_pkg::LCD_BYTES &&
         rb_addr_in < addr_map_pkg::SET1_LO) |=> s_err_ret)
        else $error("display area overrun not refused");
    a_page_refuse: assert property (
        s_read_req ##0
        (register_page_selector_out[3:0] != addr_map_pkg::LCD_PAGE &&
         {28'h0, register_page_selector_out[3:0]} >= 32'(PAGES) &&
         rb_addr_in < addr_map_pkg::SET1_LO) |=> s_err_ret)
        else $error("unimplemented page not refused");
    a_set1_reach: assert property (
        s_read_req ##0
        (rb_addr_in >= addr_map_pkg::SET1_LO && !rb_mode_in[1])
        |=> ##1 !rb_err_out)
        else $error("set 1 hidden by page selection");
    a_read_return: assert property (
        s_read_req |=> s_read_ret)
        else $error("read data not returned in two cycles");
    a_range_check: assert property (
        ##1 pm_range_err_out == ({1'b0, pm_addr_out} >= ROM_BYTES))
        else $error("program range flag wrong");
endmodule : register_file_address_map

/* cpu_core_model.sv */
`timescale 1ns/1ns
module cpu_core_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] rb_rdata_in,
    input wire logic rb_rvalid_in,
    input wire logic rb_err_in,
    output logic [7:0] rb_addr_out,
    output logic [7:0] rb_wdata_out,
    output logic [1:0] rb_mode_out,
    output logic rb_wr_out,
    output logic rb_rd_out
);
    initial begin
        rb_addr_out = 8'h00;
        rb_wdata_out = 8'h00;
        rb_mode_out = 2'h0;
        rb_wr_out = 1'b0;
        rb_rd_out = 1'b0;
    end
    // idle lines flip so a stale address never passes as valid
    task automatic release_bus();
        rb_wr_out = 1'b0;
        rb_rd_out = 1'b0;
        rb_addr_out = ~rb_addr_out;
        rb_wdata_out = ~rb_wdata_out;
    endtask : release_bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] m);
        @(negedge clk_sys_in);
        rb_addr_out = a;
        rb_wdata_out = d;
        rb_mode_out = m;
        rb_wr_out = 1'b1;
        @(negedge clk_sys_in);
        release_bus();
    endtask : wr
    // answer lands one edge after the taking edge
    task automatic rd(input logic [7:0] a, input logic [1:0] m,
                      output logic [9:0] r);
        @(negedge clk_sys_in);
        rb_addr_out = a;
        rb_mode_out = m;
        rb_rd_out = 1'b1;
        @(negedge clk_sys_in);
        release_bus();
        @(negedge clk_sys_in);
        r = {rb_rvalid_in, rb_err_in, rb_rdata_in};
    endtask : rd
endmodule : cpu_core_model

/* register_file_address_map_test.sv */
`timescale 1ns/1ns
module register_file_address_map_test;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic step = 1'b0;
    logic load = 1'b0;
    logic [15:0] target = 16'h0000;
    logic bank_zero_sel = 1'b0;
    logic bank_one_sel = 1'b0;
    logic [7:0] a, wd, rdat, psel;
    logic [1:0] m;
    logic wr, rd, rv, err, vec, rerr, bank;
    logic [15:0] pm;
    logic [9:0] r;
    int n_fail = 0;
    int num_checks = 0;
    initial forever #5 clk_sys_in = ~clk_sys_in;
    register_file_address_map #(.ROM_KB(16), .PAGES(10))
        u_register_file_address_map (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .pc_step_in(step), .pc_load_in(load),
        .pc_target_in(target), .pm_addr_out(pm), .pm_vector_out(vec),
        .pm_range_err_out(rerr), .rb_addr_in(a), .rb_wdata_in(wd),
        .rb_mode_in(m), .rb_wr_in(wr), .rb_rd_in(rd),
        .rb_rdata_out(rdat), .rb_rvalid_out(rv), .rb_err_out(err),
        .select_bank_zero_instr_in(bank_zero_sel),
        .select_bank_one_instr_in(bank_one_sel),
        .bank_sel_out(bank), .register_page_selector_out(psel));
    cpu_core_model u_cpu_core_model (.clk_sys_in(clk_sys_in),
        .rb_rdata_in(rdat), .rb_rvalid_in(rv), .rb_err_in(err),
        .rb_addr_out(a), .rb_wdata_out(wd), .rb_mode_out(m),
        .rb_wr_out(wr), .rb_rd_out(rd));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic pulse(ref logic s);
        @(negedge clk_sys_in);
        s = 1'b1;
        @(negedge clk_sys_in);
        s = 1'b0;
    endtask : pulse
    task automatic wrp(input logic [7:0] a0, d0, input logic [1:0] m0);
        u_cpu_core_model.wr(a0, d0, m0);
    endtask : wrp
    task automatic rdp(input logic [7:0] a0, input logic [1:0] m0);
        u_cpu_core_model.rd(a0, m0, r);
    endtask : rdp
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        check(pm, 16'h0100);
        check({15'h0, bank}, 16'h0000);
        check({8'h00, psel}, 16'h0000);
    endtask : test_reset
    task automatic test_program();
        pulse(step);
        check({vec, rerr, 14'h0}, 16'h0000);
        check(pm, 16'h0101);
        target = 16'h00ff;
        pulse(load);
        check({vec, rerr, pm[13:0]}, 16'h80ff);
        target = 16'h3fff;
        pulse(load);
        check({vec, rerr, 14'h0}, 16'h0000);
        pulse(step);
        check({vec, rerr, pm[13:0]}, 16'h4000);
    endtask : test_program
    task automatic test_pages();
        wrp(8'hdf, 8'h00, 2'h0);
        wrp(8'h10, 8'h5a, 2'h0);
        wrp(8'hdf, 8'h11, 2'h0);
        check({8'h00, psel}, 16'h0011);
        wrp(8'h10, 8'ha5, 2'h2);
        rdp(8'h10, 2'h0);
        check(r, 10'h2a5);
        wrp(8'hc5, 8'h3c, 2'h0);
        wrp(8'hc5, 8'h77, 2'h2);
        wrp(8'hdf, 8'h00, 2'h0);
        rdp(8'h10, 2'h3);
        check(r, 10'h25a);
        wrp(8'hc5, 8'h66, 2'h3);
        rdp(8'hc5, 2'h0);
        check(r, 10'h23c);
        rdp(8'hc5, 2'h2);
        check(r, 10'h266);
        wrp(8'hdf, 8'h11, 2'h0);
        rdp(8'hc5, 2'h3);
        check(r, 10'h277);
        rdp(8'hdf, 2'h1);
        check(r, 10'h211);
        wrp(8'hdf, 8'h33, 2'h2);
        check({8'h00, psel}, 16'h0011);
        rdp(8'hdf, 2'h3);
        check(r, 10'h233);
    endtask : test_pages
    task automatic test_banks();
        wrp(8'he3, 8'h11, 2'h0);
        wrp(8'hc3, 8'h44, 2'h0);
        pulse(bank_one_sel);
        check({15'h0, bank}, 16'h0001);
        wrp(8'he3, 8'h22, 2'h0);
        rdp(8'he3, 2'h0);
        check(r, 10'h222);
        pulse(bank_zero_sel);
        rdp(8'he3, 2'h0);
        check(r, 10'h211);
        rdp(8'hc3, 2'h0);
        check(r, 10'h244);
    endtask : test_banks
    task automatic test_unmapped();
        wrp(8'hdf, 8'haa, 2'h0);
        rdp(8'h10, 2'h0);
        check(r, 10'h300);
        rdp(8'hc3, 2'h0);
        check(r, 10'h244);
        wrp(8'hdf, 8'hff, 2'h0);
        wrp(8'h25, 8'h99, 2'h0);
        rdp(8'h25, 2'h0);
        check(r, 10'h299);
        rdp(8'h26, 2'h0);
        check(r, 10'h300);
    endtask : test_unmapped
    task automatic test_mid_reset();
        pulse(bank_one_sel);
        check({15'h0, bank}, 16'h0001);
        @(negedge clk_sys_in);
        rst_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        rst_in = 1'b0;
        check(pm, 16'h0100);
        check({15'h0, bank}, 16'h0000);
        check({8'h00, psel}, 16'h0000);
        check({6'h0, rv, err, rdat}, 16'h0000);
        rdp(8'h10, 2'h0);
        check(r, 10'h25a);
    endtask : test_mid_reset
    initial begin
        repeat (2) @(negedge clk_sys_in);
        rst_in = 1'b0;
        test_reset();
        test_program();
        test_pages();
        test_banks();
        test_unmapped();
        test_mid_reset();
        conclude();
    end
    initial begin
        #50000;
        n_fail++;
        conclude();
    end
endmodule : register_file_address_map_test
